// *** mpc_pin_ctrl.sv ***
// Pin control logic of the temperature monitor: resets, fan, over-temperature, GENERAL_PURPOSE_INPUT, test
`timescale 1ns/100ps
`default_nettype none

module mpc_pin_ctrl #(
  parameter int STRETCH_CYCLES = mpc_pkg::RESET_STRETCH_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [mpc_pkg::AV_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [mpc_pkg::AV_DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [mpc_pkg::AV_DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SUPPLY_LOW,
  input wire logic SECOND_VOLTAGE_SENSE_LOW,
  input wire logic MANUAL_RESET_N,
  input wire logic SUPPLY_RESET_IO_N_I,
  output logic SUPPLY_RESET_IO_N_O,
  output logic SUPPLY_RESET_IO_N_OE,
  input wire logic MONITOR_RESET_N_I,
  output logic MONITOR_RESET_N_O,
  output logic MONITOR_RESET_N_OE,
  output logic SELF_RESET_REQ,
  input wire logic FAN_OFF_N_I,
  output logic FAN_OFF_N_O,
  output logic FAN_OFF_N_OE,
  input wire logic NAND_TEST_ENABLE,
  output logic [7:0] FAN_SPEED_OUTPUT,
  output logic FAN_SPEED_OE,
  input wire logic TEMP_VIOLATION,
  input wire logic OVER_TEMP_I,
  output logic OVER_TEMP_O,
  output logic OVER_TEMP_OE,
  input wire logic GENERAL_PURPOSE_INPUT,
  input wire logic ADDR_STRAP_I,
  input wire logic ADDR_STRAP_OPEN,
  output logic NAND_TEST_RESULT_O,
  output logic NAND_TEST_RESULT_OE,
  output logic [6:0] BUS_ADDRESS,
  input wire logic INT_N_I,
  output logic INT_N_O,
  output logic INT_N_OE,
  output logic IRQ
);
  import mpc_pkg::*;

  localparam int CW = $clog2(STRETCH_CYCLES + 1);

  mpc_cfg_t cfg_r;
  mpc_status_t status_r;
  mpc_status_t status_nxt;
  mpc_status_t mask_r;
  logic [7:0] fan_code_r;
  logic wait_r;
  logic [AV_DATA_W-1:0] rdata_r;
  logic [1:0] rst_cond;
  logic [CW-1:0] cnt_r [2];
  logic [1:0] rst_oe_r;
  logic self_rst_r;
  logic od_low_r;
  logic fan_off_oe_r;
  logic test_r;
  logic nand_res_r;
  logic [7:0] fan_out_r;
  logic fan_oe_r;
  logic therm_oe_r;
  logic strap_done_r;
  logic [6:0] bus_addr_r;
  logic irq_r;
  logic int_oe_r;
  logic ext_therm_low;
  logic gpi_active;
  logic acc_wr;
  logic acc_rd;
  logic status_read;
  logic [ST_W-1:0] w1c;

  // Bus handshake: an access completes on the edge where waitrequest is sampled low
  assign acc_wr = AVS_WRITE && !wait_r;
  assign acc_rd = AVS_READ && !wait_r;
  assign status_read = acc_rd && (AVS_ADDRESS == OFS_STATUS);
  assign w1c = (acc_wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == OFS_STATUS) ?
               AVS_WRITEDATA[ST_W-1:0] : '0;

  // One wait cycle per access, then a single-cycle release
  always_ff @(posedge CLK) begin
    if (RST) begin
      wait_r <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // Read data is loaded on the same edge where waitrequest drops
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_r <= '0;
    end else if (AVS_READ && wait_r) begin
      case (AVS_ADDRESS)
        OFS_CONFIG: rdata_r <= {{(AV_DATA_W-CFG_W){1'b0}}, cfg_r};
        OFS_STATUS: rdata_r <= {{(AV_DATA_W-ST_W){1'b0}}, status_r};
        OFS_MASK: rdata_r <= {{(AV_DATA_W-ST_W){1'b0}}, mask_r};
        OFS_FAN_CODE: rdata_r <= {24'h000000, fan_code_r};
        OFS_PIN_STATE: rdata_r <= {24'h000000, INT_N_I, FAN_OFF_N_I, MONITOR_RESET_N_I,
                                   SUPPLY_RESET_IO_N_I, test_r, OVER_TEMP_I,
                                   GENERAL_PURPOSE_INPUT, MANUAL_RESET_N};
        OFS_BUS_ADDR: rdata_r <= {25'h0000000, bus_addr_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  // Writable control registers; unmapped writes are dropped
  // interrupt enable clears
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_r <= CFG_RESET;
      mask_r <= MASK_RESET;
      fan_code_r <= FAN_CODE_RESET;
    end else if (acc_wr && AVS_BYTEENABLE[0]) begin
      case (AVS_ADDRESS)
        OFS_CONFIG: cfg_r <= AVS_WRITEDATA[CFG_W-1:0];
        OFS_MASK: mask_r <= AVS_WRITEDATA[ST_W-1:0];
        OFS_FAN_CODE: fan_code_r <= AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end

  // Reset conditions per channel: 0 supply line, 1 monitor line
  // monitor covers all causes
  assign rst_cond[0] = SUPPLY_LOW;
  assign rst_cond[1] = SUPPLY_LOW || SECOND_VOLTAGE_SENSE_LOW || !MANUAL_RESET_N;

  // Stretch counters; power-on reset itself starts a full stretch
  // cycle counter stretch
  for (genvar g = 0; g < 2; g++) begin : g_stretch
    always_ff @(posedge CLK) begin
      if (RST) begin
        cnt_r[g] <= CW'(STRETCH_CYCLES);
        rst_oe_r[g] <= 1'b1;
      end else begin
        rst_oe_r[g] <= rst_cond[g] || (cnt_r[g] != '0);
        if (rst_cond[g]) begin
          cnt_r[g] <= CW'(STRETCH_CYCLES);
        end else if (cnt_r[g] != '0) begin
          cnt_r[g] <= cnt_r[g] - 1'b1;
        end
      end
    end
  end

  // External pull on the supply line while we release it is a self-reset request
  // bidirectional reset input
  always_ff @(posedge CLK) begin
    if (RST) begin
      self_rst_r <= 1'b0;
    end else begin
      self_rst_r <= !SUPPLY_RESET_IO_N_I && !rst_oe_r[0];
    end
  end

  // Open-drain pins only ever drive low
  always_ff @(posedge CLK) begin
    if (RST) begin
      od_low_r <= 1'b0;
    end else begin
      od_low_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fan_off_oe_r <= 1'b0;
    end else begin
      fan_off_oe_r <= cfg_r.fan_off;
    end
  end

  // Pulled low from outside while we are not driving it ourselves
  assign ext_therm_low = cfg_r.therm_digital && !OVER_TEMP_I && !therm_oe_r;
  // GENERAL_PURPOSE_INPUT active level follows the programmed polarity
  assign gpi_active = cfg_r.gpi_digital &&
                      (GENERAL_PURPOSE_INPUT == cfg_r.gpi_active_high);

  always_ff @(posedge CLK) begin
    if (RST) begin
      therm_oe_r <= 1'b0;
    end else begin
      therm_oe_r <= cfg_r.therm_digital && TEMP_VIOLATION;
    end
  end

  // Test mode and fan drive; the fan pin is released while test equipment owns it
  // NAND test select
  always_ff @(posedge CLK) begin
    if (RST) begin
      test_r <= 1'b0;
      fan_oe_r <= 1'b1;
      fan_out_r <= FAN_CODE_RESET;
    end else begin
      test_r <= NAND_TEST_ENABLE;
      // Registered release keeps the fan pin output straight from a flop
      fan_oe_r <= !NAND_TEST_ENABLE;
      if (ext_therm_low || TEMP_VIOLATION) begin
        fan_out_r <= FAN_FULL;
      end else begin
        fan_out_r <= fan_code_r;
      end
    end
  end

  // NAND tree over the digital inputs, shown on the strap pin in test mode
  // strap pin as result
  always_ff @(posedge CLK) begin
    if (RST) begin
      nand_res_r <= 1'b0;
    end else begin
      nand_res_r <= !(MANUAL_RESET_N && GENERAL_PURPOSE_INPUT && OVER_TEMP_I &&
                      SUPPLY_RESET_IO_N_I);
    end
  end

  // Strap caught once, first cycle after power-on reset; later pin changes are ignored
  // power-up sample only
  always_ff @(posedge CLK) begin
    if (RST) begin
      strap_done_r <= 1'b0;
      bus_addr_r <= '0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      if (ADDR_STRAP_OPEN) begin
        bus_addr_r <= {BUS_ADDR_UPPER, STRAP_CODE_OPEN};
      end else if (ADDR_STRAP_I) begin
        bus_addr_r <= {BUS_ADDR_UPPER, STRAP_CODE_HIGH};
      end else begin
        bus_addr_r <= {BUS_ADDR_UPPER, STRAP_CODE_LOW};
      end
    end
  end

  // Sticky status: hardware set wins over a software clear in the same cycle
  always_comb begin
    status_nxt = status_r & ~mpc_status_t'(w1c);
    status_nxt.general_purpose_input = status_r.general_purpose_input && !(status_read && !gpi_active);
    status_nxt.trip = status_nxt.trip || TEMP_VIOLATION;
    status_nxt.therm_ext = status_nxt.therm_ext || ext_therm_low;
    status_nxt.sup_rst = status_nxt.sup_rst || rst_cond[0];
    status_nxt.mon_rst = status_nxt.mon_rst || rst_cond[1];
    status_nxt.general_purpose_input = status_nxt.general_purpose_input || gpi_active;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Interrupt: level output from masked status; pin only when enabled
  // gated by config bit 1
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_r <= 1'b0;
      int_oe_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r);
      int_oe_r <= cfg_r.int_enable && TEMP_VIOLATION;
    end
  end

  assign AVS_READDATA = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign SUPPLY_RESET_IO_N_OE = rst_oe_r[0];
  assign SUPPLY_RESET_IO_N_O = od_low_r;
  assign MONITOR_RESET_N_OE = rst_oe_r[1];
  assign MONITOR_RESET_N_O = od_low_r;
  assign SELF_RESET_REQ = self_rst_r;
  assign FAN_OFF_N_OE = fan_off_oe_r;
  assign FAN_OFF_N_O = od_low_r;
  assign FAN_SPEED_OUTPUT = fan_out_r;
  assign FAN_SPEED_OE = fan_oe_r;
  assign OVER_TEMP_OE = therm_oe_r;
  assign OVER_TEMP_O = od_low_r;
  assign NAND_TEST_RESULT_O = nand_res_r;
  assign NAND_TEST_RESULT_OE = test_r;
  assign BUS_ADDRESS = bus_addr_r;
  assign INT_N_OE = int_oe_r;
  assign INT_N_O = od_low_r;
  assign IRQ = irq_r;

  // Helper: cycles since each reset condition last ended
  int quiet_r [2];
  always_ff @(posedge CLK) begin
    if (RST) begin
      quiet_r[0] <= 0;
      quiet_r[1] <= 0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rst_cond[i]) begin
          quiet_r[i] <= 0;
        end else if (quiet_r[i] < STRETCH_CYCLES + 4) begin
          quiet_r[i] <= quiet_r[i] + 1;
        end
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_fan_off_req: assert property (cfg_r.fan_off |=> FAN_OFF_N_OE)
    else $error("fan off request not driven");
  a_manual_hold: assert property (!MANUAL_RESET_N |=> MONITOR_RESET_N_OE[*1])
    else $error("monitor reset not asserted by manual reset");
  a_mon_stretch: assert property ($fell(MONITOR_RESET_N_OE) |-> quiet_r[1] == STRETCH_CYCLES + 1)
    else $error("monitor reset stretch length wrong");
  a_sup_stretch: assert property ($fell(SUPPLY_RESET_IO_N_OE) |-> quiet_r[0] == STRETCH_CYCLES + 1)
    else $error("supply reset stretch length wrong");
  a_self_reset: assert property (!SUPPLY_RESET_IO_N_I && !SUPPLY_RESET_IO_N_OE |=> SELF_RESET_REQ)
    else $error("external reset pull not seen");
  a_mon_causes: assert property (SECOND_VOLTAGE_SENSE_LOW || SUPPLY_LOW |=> MONITOR_RESET_N_OE ##1 MONITOR_RESET_N_OE)
    else $error("monitor reset ignores a supply cause");
  a_nand_mode: assert property (NAND_TEST_ENABLE |=> !FAN_SPEED_OE && NAND_TEST_RESULT_OE)
    else $error("test mode not entered");
  a_nand_out: assert property (!NAND_TEST_ENABLE |=> !NAND_TEST_RESULT_OE && FAN_SPEED_OE)
    else $error("strap pin driven outside test mode");
  a_therm_drive: assert property (cfg_r.therm_digital && TEMP_VIOLATION |=> OVER_TEMP_OE)
    else $error("over-temperature pin not driven");
  a_ext_therm: assert property (ext_therm_low |=> status_r.therm_ext && FAN_SPEED_OUTPUT == FAN_FULL)
    else $error("external over-temperature not handled");
  a_gpi_set: assert property (gpi_active |=> status_r.general_purpose_input)
    else $error("GENERAL_PURPOSE_INPUT did not set status bit 4");
  a_gpi_keep: assert property (status_r.general_purpose_input && !status_read |=> status_r.general_purpose_input)
    else $error("GENERAL_PURPOSE_INPUT status lost without a read");
  a_strap_fixed: assert property (strap_done_r |=> $stable(BUS_ADDRESS))
    else $error("bus address changed after power-up");
  a_int_gate: assert property (!cfg_r.int_enable |=> !INT_N_OE)
    else $error("interrupt pin driven while disabled");
  a_int_reset: assert property (@(posedge CLK) $past(RST) |-> !cfg_r.int_enable && !INT_N_OE)
    else $error("interrupt enable not cleared by reset");
  a_addr_upper: assert property (strap_done_r |-> BUS_ADDRESS[6:2] == BUS_ADDR_UPPER)
    else $error("bus address upper bits wrong");
  a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) // Bus timing
    else $error("bus answer not in one cycle");

  c_manual_pulse: cover property ($rose(MANUAL_RESET_N) ##[1:8] MONITOR_RESET_N_OE);
  c_gpi_clear: cover property (status_r.general_purpose_input && status_read && !gpi_active ##1 !status_r.general_purpose_input);
  c_int_pin: cover property (cfg_r.int_enable && TEMP_VIOLATION ##1 INT_N_OE);
  c_nand_test: cover property (NAND_TEST_ENABLE ##1 NAND_TEST_RESULT_OE);

endmodule

`default_nettype wire

// *** mpc_pkg.sv ***
// Constants, field layouts and carrier types for the monitor pin control block
package mpc_pkg;

  // Avalon-MM slave geometry
  localparam int AV_ADDR_W = 8;
  localparam int AV_DATA_W = 32;

  // Register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_FAN_CODE = 8'h0C;
  localparam logic [7:0] OFS_PIN_STATE = 8'h10;
  localparam logic [7:0] OFS_BUS_ADDR = 8'h14;

  // Configuration field positions
  localparam int CFG_FAN_OFF_BIT = 0;
  localparam int CFG_INT_EN_BIT = 1;
  localparam int CFG_THERM_DIG_BIT = 2;
  localparam int CFG_GPI_DIG_BIT = 3;
  localparam int CFG_GPI_HIGH_BIT = 4;
  localparam int CFG_W = 5;

  // Status / mask field positions
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_THERM_EXT_BIT = 1;
  localparam int ST_SUP_RST_BIT = 2;
  localparam int ST_MON_RST_BIT = 3;
  localparam int ST_GPI_BIT = 4;
  localparam int ST_W = 5;

  // Reset values and full fan code
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
  localparam logic [ST_W-1:0] MASK_RESET = 5'h00;
  localparam logic [7:0] FAN_CODE_RESET = 8'h00;
  localparam logic [7:0] FAN_FULL = 8'hFF;

  // Serial bus address: fixed upper part, strap-coded lower part
  localparam logic [4:0] BUS_ADDR_UPPER = 5'h0B;
  localparam logic [1:0] STRAP_CODE_LOW = 2'h2;
  localparam logic [1:0] STRAP_CODE_OPEN = 2'h0;
  localparam logic [1:0] STRAP_CODE_HIGH = 2'h1;

  // Reset stretch timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_STRETCH_TIME_NS = 200000;
  localparam int RESET_STRETCH_CYCLES =
    (RESET_STRETCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Configuration carrier
  typedef struct packed {
    logic gpi_active_high;
    logic gpi_digital;
    logic therm_digital;
    logic int_enable;
    logic fan_off;
  } mpc_cfg_t;

  // Status and mask carrier
  typedef struct packed {
    logic general_purpose_input;
    logic mon_rst;
    logic sup_rst;
    logic therm_ext;
    logic trip;
  } mpc_status_t;

endpackage

// *** mpc_far_side.sv ***
// Far-side model: reset consumers, fan driver and board tester on the open-drain pins
`timescale 1ns/100ps
`default_nettype none

module mpc_far_side (
  input wire logic sup_oe,
  input wire logic sup_pull,
  output logic sup_lvl,
  output logic aux_rst_n,
  input wire logic mon_oe,
  output logic mon_lvl,
  input wire logic fan_off_oe,
  output logic fan_off_lvl,
  input wire logic ot_oe,
  input wire logic ot_pull,
  output logic ot_lvl,
  input wire logic int_oe,
  output logic int_lvl,
  input wire logic strap_oe,
  input wire logic strap_o,
  input wire logic strap_set,
  output logic strap_lvl,
  input wire logic test_req,
  output logic test_en
);
  // Pulled-up lines read low while any party pulls them
  assign sup_lvl = ~(sup_oe | sup_pull);
  assign mon_lvl = ~mon_oe;
  assign fan_off_lvl = ~fan_off_oe;
  assign ot_lvl = ~(ot_oe | ot_pull);
  assign int_lvl = ~int_oe;
  // auxiliary reset blocked
  // Our own pull must not ripple into the system auxiliary reset
  assign aux_rst_n = sup_pull ? 1'b1 : sup_lvl;
  assign test_en = test_req;
  // Strap pin: device output wins in test mode, else the board level
  assign strap_lvl = strap_oe ? strap_o : strap_set;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the monitor pin control block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import mpc_pkg::*;
  localparam int S = 8;
  logic CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [AV_ADDR_W-1:0] AVS_ADDRESS;
  logic [AV_DATA_W-1:0] AVS_WRITEDATA, AVS_READDATA;
  logic SUPPLY_LOW, SECOND_VOLTAGE_SENSE_LOW, MANUAL_RESET_N, SUPPLY_RESET_IO_N_I;
  logic SUPPLY_RESET_IO_N_OE, MONITOR_RESET_N_I, MONITOR_RESET_N_OE, SELF_RESET_REQ;
  logic FAN_OFF_N_I, FAN_OFF_N_OE, NAND_TEST_ENABLE, FAN_SPEED_OE, TEMP_VIOLATION;
  logic OVER_TEMP_I, OVER_TEMP_OE, GENERAL_PURPOSE_INPUT, ADDR_STRAP_I, ADDR_STRAP_OPEN;
  logic NAND_TEST_RESULT_O, NAND_TEST_RESULT_OE, INT_N_I, INT_N_OE, IRQ;
  logic [7:0] FAN_SPEED_OUTPUT;
  logic [6:0] BUS_ADDRESS;
  logic sup_pull, ot_pull, strap_set, test_req, aux_rst_n;
  logic [31:0] rd;
  int failures, checked, cycles;

  mpc_pin_ctrl #(.STRETCH_CYCLES(S)) dut (
    .CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA, .AVS_WAITREQUEST, .SUPPLY_LOW, .SECOND_VOLTAGE_SENSE_LOW, .MANUAL_RESET_N,
    .SUPPLY_RESET_IO_N_I, .SUPPLY_RESET_IO_N_O(), .SUPPLY_RESET_IO_N_OE, .MONITOR_RESET_N_I,
    .MONITOR_RESET_N_O(), .MONITOR_RESET_N_OE, .SELF_RESET_REQ, .FAN_OFF_N_I, .FAN_OFF_N_O(),
    .FAN_OFF_N_OE, .NAND_TEST_ENABLE, .FAN_SPEED_OUTPUT, .FAN_SPEED_OE, .TEMP_VIOLATION,
    .OVER_TEMP_I, .OVER_TEMP_O(), .OVER_TEMP_OE, .GENERAL_PURPOSE_INPUT, .ADDR_STRAP_I,
    .ADDR_STRAP_OPEN, .NAND_TEST_RESULT_O, .NAND_TEST_RESULT_OE, .BUS_ADDRESS, .INT_N_I,
    .INT_N_O(), .INT_N_OE, .IRQ);

  mpc_far_side far (
    .sup_oe(SUPPLY_RESET_IO_N_OE), .sup_pull, .sup_lvl(SUPPLY_RESET_IO_N_I), .aux_rst_n,
    .mon_oe(MONITOR_RESET_N_OE), .mon_lvl(MONITOR_RESET_N_I), .fan_off_oe(FAN_OFF_N_OE),
    .fan_off_lvl(FAN_OFF_N_I), .ot_oe(OVER_TEMP_OE), .ot_pull, .ot_lvl(OVER_TEMP_I),
    .int_oe(INT_N_OE), .int_lvl(INT_N_I), .strap_oe(NAND_TEST_RESULT_OE),
    .strap_o(NAND_TEST_RESULT_O), .strap_set, .strap_lvl(ADDR_STRAP_I), .test_req,
    .test_en(NAND_TEST_ENABLE));

  // 10 MHz clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up;
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait n edges, then let that edge's updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= 1'b1;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
    AVS_WRITE <= 1'b0;
  endtask

  task automatic av_rd(input logic [7:0] a);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_READ <= 1'b1;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
  endtask

  // Line stays driven S cycles after its cause drops, then releases
  task automatic stretch(input logic sup);
    tick(S);
    chk_bit(sup ? SUPPLY_RESET_IO_N_OE : MONITOR_RESET_N_OE, 1'b1);
    tick(1);
    chk_bit(sup ? SUPPLY_RESET_IO_N_OE : MONITOR_RESET_N_OE, 1'b0);
  endtask

  task automatic t_reset;
    tick(1);
    chk_bit(SUPPLY_RESET_IO_N_OE, 1'b1); // power-up stretch
    tick(S + 3);
    chk_bit(SUPPLY_RESET_IO_N_OE, 1'b0); // stretch ends
    chk_word({25'h0, BUS_ADDRESS}, {25'h0, BUS_ADDR_UPPER, STRAP_CODE_HIGH}); // strap high
    av_rd(OFS_BUS_ADDR);
    chk_word(rd, {25'h0, BUS_ADDR_UPPER, STRAP_CODE_HIGH}); // readback
    av_rd(OFS_CONFIG);
    chk_word(rd, 32'h0); // enable clear
    av_wr(8'h20, 32'hFF);
    av_rd(8'h20);
    chk_word(rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_irq;
    @(posedge CLK);
    TEMP_VIOLATION <= 1'b1;
    tick(3);
    chk_bit(INT_N_OE, 1'b0); // pin released
    av_wr(OFS_CONFIG, 32'h02);
    tick(2);
    chk_bit(INT_N_OE, 1'b1); // pin enabled
    chk_bit(IRQ, 1'b0);
    av_wr(OFS_MASK, 32'h01);
    tick(2);
    chk_bit(IRQ, 1'b1);
    av_rd(OFS_MASK);
    chk_word(rd, 32'h01);
    @(posedge CLK);
    TEMP_VIOLATION <= 1'b0;
    tick(2);
    chk_bit(INT_N_OE, 1'b0); // follows TEMP_VIOLATION, not sticky trip
    chk_bit(IRQ, 1'b1);
    av_wr(OFS_STATUS, 32'h01);
    tick(2);
    chk_bit(IRQ, 1'b0);
    av_wr(OFS_MASK, 32'h0);
    av_wr(OFS_CONFIG, 32'h0);
    $display("test irq done");
  endtask

  task automatic t_therm;
    av_wr(OFS_CONFIG, 32'h04);
    av_wr(OFS_FAN_CODE, 32'h40);
    av_rd(OFS_FAN_CODE);
    chk_word(rd, 32'h40);
    @(posedge CLK);
    TEMP_VIOLATION <= 1'b1;
    tick(3);
    chk_bit(OVER_TEMP_OE, 1'b1); // drive on violation
    chk_word({24'h0, FAN_SPEED_OUTPUT}, {24'h0, FAN_FULL});
    @(posedge CLK);
    TEMP_VIOLATION <= 1'b0;
    tick(3);
    chk_bit(OVER_TEMP_OE, 1'b0); // release
    chk_word({24'h0, FAN_SPEED_OUTPUT}, 32'h40);
    @(posedge CLK);
    ot_pull <= 1'b1;
    tick(3);
    chk_word({24'h0, FAN_SPEED_OUTPUT}, {24'h0, FAN_FULL}); // fan full
    @(posedge CLK);
    ot_pull <= 1'b0;
    av_rd(OFS_STATUS);
    chk_bit(rd[ST_THERM_EXT_BIT], 1'b1); // status set
    av_wr(OFS_CONFIG, 32'h01);
    tick(2);
    chk_bit(FAN_OFF_N_OE, 1'b1); // shutdown request
    chk_word({24'h0, FAN_SPEED_OUTPUT}, 32'h40); // independent of speed
    av_rd(OFS_PIN_STATE);
    chk_word(rd, 32'hB5); // pin reads low
    av_wr(OFS_CONFIG, 32'h0);
    tick(2);
    chk_bit(FAN_OFF_N_OE, 1'b0); // released
    $display("test therm done");
  endtask

  task automatic t_gpi;
    logic lvl;
    for (int p = 0; p < 2; p++) begin
      lvl = p[0];
      @(posedge CLK);
      GENERAL_PURPOSE_INPUT <= ~lvl;
      av_wr(OFS_CONFIG, {27'h0, lvl, 4'h8});
      av_rd(OFS_STATUS);
      @(posedge CLK);
      GENERAL_PURPOSE_INPUT <= lvl;
      tick(2);
      av_rd(OFS_STATUS);
      chk_bit(rd[ST_GPI_BIT], 1'b1); // both polarities
      av_rd(OFS_STATUS);
      chk_bit(rd[ST_GPI_BIT], 1'b1); // held while active
      @(posedge CLK);
      GENERAL_PURPOSE_INPUT <= ~lvl;
      tick(2);
      av_rd(OFS_STATUS);
      chk_bit(rd[ST_GPI_BIT], 1'b1); // sticky
      av_rd(OFS_STATUS);
      chk_bit(rd[ST_GPI_BIT], 1'b0); // cleared by read
    end
    av_wr(OFS_CONFIG, 32'h0);
    $display("test gpi done");
  endtask

  task automatic t_resets;
    @(posedge CLK);
    MANUAL_RESET_N <= 1'b0;
    tick(3);
    chk_bit(MONITOR_RESET_N_OE, 1'b1); // manual reset
    chk_bit(SUPPLY_RESET_IO_N_OE, 1'b0);
    @(posedge CLK);
    MANUAL_RESET_N <= 1'b1;
    stretch(1'b0); // stretch count
    @(posedge CLK);
    SECOND_VOLTAGE_SENSE_LOW <= 1'b1;
    tick(3);
    chk_bit(MONITOR_RESET_N_OE, 1'b1); // second sense
    chk_bit(SUPPLY_RESET_IO_N_OE, 1'b0);
    @(posedge CLK);
    SECOND_VOLTAGE_SENSE_LOW <= 1'b0;
    stretch(1'b0); // stretch count
    @(posedge CLK);
    SUPPLY_LOW <= 1'b1;
    tick(3);
    chk_bit(MONITOR_RESET_N_OE, 1'b1); // supply covers both
    chk_bit(SELF_RESET_REQ, 1'b0); // own drive ignored
    chk_bit(aux_rst_n, 1'b0); // device reset passed on
    @(posedge CLK);
    SUPPLY_LOW <= 1'b0;
    stretch(1'b1); // supply stretch
    chk_bit(MONITOR_RESET_N_OE, 1'b0); // both released
    @(posedge CLK);
    sup_pull <= 1'b1;
    tick(3);
    chk_bit(SELF_RESET_REQ, 1'b1); // outside pull
    chk_bit(aux_rst_n, 1'b1); // auxiliary reset blocked
    @(posedge CLK);
    sup_pull <= 1'b0;
    tick(S + 4);
    chk_bit(SELF_RESET_REQ, 1'b0); // pull gone
    $display("test resets done");
  endtask

  task automatic t_nand;
    @(posedge CLK);
    test_req <= 1'b1;
    tick(3);
    chk_bit(FAN_SPEED_OE, 1'b0); // test selected
    chk_bit(NAND_TEST_RESULT_OE, 1'b1); // strap driven
    // GENERAL_PURPOSE_INPUT low, all other tree inputs high: tree output high
    chk_bit(NAND_TEST_RESULT_O, 1'b1); // result
    @(posedge CLK);
    GENERAL_PURPOSE_INPUT <= 1'b1;
    tick(3);
    chk_bit(NAND_TEST_RESULT_O, 1'b0); // result
    @(posedge CLK);
    test_req <= 1'b0;
    strap_set <= 1'b0;
    tick(3);
    chk_bit(FAN_SPEED_OE, 1'b1); // normal use
    chk_bit(NAND_TEST_RESULT_OE, 1'b0); // strap released
    chk_word({25'h0, BUS_ADDRESS}, {25'h0, BUS_ADDR_UPPER, STRAP_CODE_HIGH}); // no resample
    @(posedge CLK);
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    tick(2);
    chk_word({25'h0, BUS_ADDRESS}, {25'h0, BUS_ADDR_UPPER, STRAP_CODE_LOW}); // strap low
    @(posedge CLK);
    ADDR_STRAP_OPEN <= 1'b1;
    RST <= 1'b1;
    @(posedge CLK);
    RST <= 1'b0;
    tick(2);
    chk_word({25'h0, BUS_ADDRESS}, {25'h0, BUS_ADDR_UPPER, STRAP_CODE_OPEN}); // strap open
    @(posedge CLK);
    ADDR_STRAP_OPEN <= 1'b0;
    tick(3);
    chk_word({25'h0, BUS_ADDRESS}, {25'h0, BUS_ADDR_UPPER, STRAP_CODE_OPEN}); // change ignored
    $display("test nand done");
  endtask

  // Main sequence
  initial begin
    RST = 1'b1;
    AVS_ADDRESS = '0;
    AVS_WRITEDATA = '0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    SUPPLY_LOW = 1'b0;
    SECOND_VOLTAGE_SENSE_LOW = 1'b0;
    MANUAL_RESET_N = 1'b1;
    TEMP_VIOLATION = 1'b0;
    GENERAL_PURPOSE_INPUT = 1'b0;
    ADDR_STRAP_OPEN = 1'b0;
    sup_pull = 1'b0;
    ot_pull = 1'b0;
    strap_set = 1'b1;
    test_req = 1'b0;
    failures = 0;
    checked = 0;
    cycles = 0;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    t_reset;
    t_irq;
    t_therm;
    t_gpi;
    t_resets;
    t_nand;
    wrap_up;
  end
endmodule
`default_nettype wire
